// ==== rtl/api_frame_codec_defines.vh ====
// constants for the serial api frame codec (host end)
// assumes byte-wide streams on a single clock
`ifndef API_FRAME_CODEC_DEFINES_VH
`define API_FRAME_CODEC_DEFINES_VH
`define START_BYTE     8'h7E
`define ESC_BYTE       8'h7D
`define XON_BYTE       8'h11
`define XOFF_BYTE      8'h13
`define ESC_XOR        8'h20
`define CSUM_BASE      8'hFF
`define CSUM_GOOD      8'hFF
`define MODE_TRANSP    2'h0
`define MODE_PLAIN     2'h1
`define MODE_ESCAPED   2'h2
`define ERR_NONE       2'h0
`define ERR_CSUM       2'h1
`define ERR_ABORT      2'h2
`define ERR_EMPTY      2'h3
`endif

// ==== rtl/byte_skid.v ====
// two-entry byte buffer with valid/ready on both sides
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module byte_skid (
   input  wire       clk,
   input  wire       rst,
   input  wire [8:0] in_data,
   input  wire       in_valid,
   output wire       in_ready,
   output wire [8:0] out_data,
   output wire       out_valid,
   input  wire       out_ready
);
   reg [8:0] mem_q [0:1];
   reg       wr_q;
   reg       rd_q;
   reg [1:0] cnt_q;
   wire      push;
   wire      pop;
   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         cnt_q    <= 2'h0;
         mem_q[0] <= 9'h000;
         mem_q[1] <= 9'h000;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q        <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // byte_skid
`default_nettype wire

// ==== rtl/api_frame_codec.v ====
// host-side framer and deframer for the structured serial api
// assumes serial bytes leave as a valid-ready byte stream and arrive with valid only, on clk
`timescale 1ns/1ns
`default_nettype none
`include "api_frame_codec_defines.vh"
// Notes on behaviour
// - every frame starts with byte 7E; receiver resyncs on it
// - two-byte length follows, high byte first, counts data bytes only
// - data follows length, first byte frame type, then one checksum byte
// - escaped byte sent as 7D then byte xor 20
// - escape 7E, 7D, 11 and 13
// - escaping covers length, data, checksum but never the delimiter
// - length counts unescaped data bytes only
// - checksum over unescaped values
// - escape on send and unescape on receive only in escaped mode
// - multi-byte values travel high byte first
// - checksum is FF minus low byte of data sum
module api_frame_codec (
   input  wire       clk,
   input  wire       rst,
   input  wire [1:0] api_mode_select,
   input  wire [7:0] tx_data,
   input  wire       tx_valid,
   input  wire       tx_last,
   output wire       tx_ready,
   output reg  [7:0] ser_tx_data,
   output reg        ser_tx_valid,
   input  wire       ser_tx_ready,
   input  wire [7:0] ser_rx_data,
   input  wire       ser_rx_valid,
   output reg  [7:0] rx_data,
   output reg        rx_valid,
   output reg        rx_last,
   output reg        rx_frame_ok,
   output reg        rx_frame_err,
   output reg  [1:0] rx_err_code,
   input  wire       rx_ready,
   output reg        rx_overflow
);
   function needs_esc;
      input [7:0] b;
      begin
         needs_esc = (b == `START_BYTE) | (b == `ESC_BYTE) | (b == `XON_BYTE) | (b == `XOFF_BYTE);
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // transmit: frame buffer, then serialise
   localparam T_IDLE = 3'h0;
   localparam T_SOF  = 3'h1;
   localparam T_LENH = 3'h2;
   localparam T_LENL = 3'h3;
   localparam T_DATA = 3'h4;
   localparam T_CSUM = 3'h5;
   localparam T_ESC2 = 3'h6;
   localparam T_FILL = 3'h7;
   reg  [7:0]  tbuf [0:255];
   reg  [2:0]  t_st_q;
   reg  [2:0]  t_ret_q;
   reg  [8:0]  t_len_q;
   reg  [8:0]  t_idx_q;
   reg  [7:0]  t_sum_q;
   reg  [7:0]  t_pend_q;
   wire        t_esc_on;
   wire        t_free;
   reg  [7:0]  t_byte;
   assign t_esc_on = (api_mode_select == `MODE_ESCAPED);
   assign tx_ready = (t_st_q == T_FILL) | (t_st_q == T_IDLE);
   assign t_free   = ~ser_tx_valid | ser_tx_ready;
   always @* begin
      case (t_st_q)
         T_LENH:  t_byte = {7'h00, t_len_q[8]};
         T_LENL:  t_byte = t_len_q[7:0];
         T_DATA:  t_byte = tbuf[t_idx_q[7:0]];
         T_CSUM:  t_byte = `CSUM_BASE - t_sum_q;
         default: t_byte = 8'h00;
      endcase
   end
   always @(posedge clk) begin
      if (tx_valid & tx_ready)
         tbuf[t_len_q[7:0]] <= tx_data;
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         t_st_q       <= T_IDLE;
         t_ret_q      <= T_IDLE;
         t_len_q      <= 9'h000;
         t_idx_q      <= 9'h000;
         t_sum_q      <= 8'h00;
         t_pend_q     <= 8'h00;
         ser_tx_data  <= 8'h00;
         ser_tx_valid <= 1'b0;
      end else begin
         if (ser_tx_valid & ser_tx_ready)
            ser_tx_valid <= 1'b0;
         case (t_st_q)
            T_IDLE, T_FILL: begin
               if (tx_valid & (api_mode_select == `MODE_TRANSP)) begin
                  if (t_free) begin
                     ser_tx_data  <= tx_data;
                     ser_tx_valid <= 1'b1;
                  end
               end else if (tx_valid) begin
                  t_len_q <= t_len_q + 9'h001;
                  t_sum_q <= t_sum_q + tx_data;
                  t_st_q  <= (tx_last | (t_len_q[7:0] == 8'hFF)) ? T_SOF : T_FILL;
               end
            end
            T_SOF: if (t_free) begin
               ser_tx_data  <= `START_BYTE;
               ser_tx_valid <= 1'b1;
               t_st_q       <= T_LENH;
            end
            T_LENH, T_LENL, T_DATA, T_CSUM: if (t_free) begin
               ser_tx_valid <= 1'b1;
               if (t_esc_on & needs_esc(t_byte)) begin
                  ser_tx_data <= `ESC_BYTE;
                  t_pend_q    <= t_byte ^ `ESC_XOR;
                  t_st_q      <= T_ESC2;
               end else begin
                  ser_tx_data <= t_byte;
               end
               // length high then low, then data
               case (t_st_q)
                  T_LENH:  t_ret_q <= T_LENL;
                  T_LENL:  t_ret_q <= T_DATA;
                  T_DATA:  t_ret_q <= (t_idx_q + 9'h001 == t_len_q) ? T_CSUM : T_DATA;
                  default: t_ret_q <= T_IDLE;
               endcase
               if (t_st_q == T_DATA)
                  t_idx_q <= t_idx_q + 9'h001;
               if (~(t_esc_on & needs_esc(t_byte))) begin
                  case (t_st_q)
                     T_LENH:  t_st_q <= T_LENL;
                     T_LENL:  t_st_q <= T_DATA;
                     T_DATA:  t_st_q <= (t_idx_q + 9'h001 == t_len_q) ? T_CSUM : T_DATA;
                     default: t_st_q <= T_IDLE;
                  endcase
               end
               if (t_st_q == T_CSUM) begin
                  t_len_q <= 9'h000;
                  t_idx_q <= 9'h000;
                  t_sum_q <= 8'h00;
               end
            end
            T_ESC2: if (t_free) begin
               ser_tx_data  <= t_pend_q;
               ser_tx_valid <= 1'b1;
               t_st_q       <= t_ret_q;
            end
            default: t_st_q <= T_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // receive: deframer into the two-entry buffer
   localparam R_HUNT = 3'h0;
   localparam R_LENH = 3'h1;
   localparam R_LENL = 3'h2;
   localparam R_DATA = 3'h3;
   localparam R_CSUM = 3'h4;
   reg  [2:0]  r_st_q;
   reg  [15:0] r_len_q;
   reg  [15:0] r_cnt_q;
   reg  [7:0]  r_sum_q;
   reg         r_esc_q;
   reg  [7:0]  r_hold_q;
   reg         r_have_q;
   reg  [8:0]  b_in;
   reg         b_in_v;
   wire        b_in_rdy;
   wire [8:0]  b_out;
   wire        b_out_v;
   wire        r_esc_on;
   wire        r_raw_sof;
   wire [7:0]  r_val;
   wire        r_take;
   assign r_esc_on  = (api_mode_select == `MODE_ESCAPED);
   assign r_raw_sof = ser_rx_valid & (ser_rx_data == `START_BYTE);
   assign r_val     = r_esc_q ? (ser_rx_data ^ `ESC_XOR) : ser_rx_data;
   assign r_take    = ser_rx_valid & ~(r_esc_on & ~r_esc_q & (ser_rx_data == `ESC_BYTE));
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         r_st_q       <= R_HUNT;
         r_len_q      <= 16'h0000;
         r_cnt_q      <= 16'h0000;
         r_sum_q      <= 8'h00;
         r_esc_q      <= 1'b0;
         r_hold_q     <= 8'h00;
         r_have_q     <= 1'b0;
         b_in         <= 9'h000;
         b_in_v       <= 1'b0;
         rx_frame_ok  <= 1'b0;
         rx_frame_err <= 1'b0;
         rx_err_code  <= `ERR_NONE;
         rx_overflow  <= 1'b0;
      end else begin
         rx_frame_ok  <= 1'b0;
         rx_frame_err <= 1'b0;
         // staged byte refused by a full buffer is lost
         rx_overflow  <= b_in_v & ~b_in_rdy;
         b_in_v       <= 1'b0;
         if (ser_rx_valid & r_esc_on)
            r_esc_q <= ~r_esc_q & (ser_rx_data == `ESC_BYTE);
         if (api_mode_select == `MODE_TRANSP) begin
            r_st_q <= R_HUNT;
            if (ser_rx_valid) begin
               b_in        <= {1'b0, ser_rx_data};
               b_in_v      <= 1'b1;
            end
         // unescaped start byte restarts the frame
         end else if (r_raw_sof & ~(r_esc_on & r_esc_q)) begin
            if (r_st_q != R_HUNT) begin
               rx_frame_err <= 1'b1;
               rx_err_code  <= `ERR_ABORT;
            end
            r_st_q   <= R_LENH;
            r_sum_q  <= 8'h00;
            r_cnt_q  <= 16'h0000;
            r_have_q <= 1'b0;
         end else if (r_take) begin
            case (r_st_q)
               // bytes before a start byte are dropped
               R_HUNT: r_st_q <= R_HUNT;
               R_LENH: begin
                  r_len_q[15:8] <= r_val;
                  r_st_q        <= R_LENL;
               end
               R_LENL: begin
                  r_len_q[7:0] <= r_val;
                  r_st_q       <= ({r_len_q[15:8], r_val} == 16'h0000) ? R_CSUM : R_DATA;
               end
               R_DATA: begin
                  // count data bytes, hold one back
                  r_sum_q  <= r_sum_q + r_val;
                  r_cnt_q  <= r_cnt_q + 16'h0001;
                  r_hold_q <= r_val;
                  r_have_q <= 1'b1;
                  if (r_have_q) begin
                     b_in        <= {1'b0, r_hold_q};
                     b_in_v      <= 1'b1;
                  end
                  if (r_cnt_q + 16'h0001 == r_len_q)
                     r_st_q <= R_CSUM;
               end
               R_CSUM: begin
                  r_st_q   <= R_HUNT;
                  r_have_q <= 1'b0;
                  if (((r_sum_q + r_val) == `CSUM_GOOD) & r_have_q) begin
                     b_in        <= {1'b1, r_hold_q};
                     b_in_v      <= 1'b1;
                     rx_frame_ok <= 1'b1;
                  end else begin
                     rx_frame_err <= 1'b1;
                     rx_err_code  <= r_have_q ? `ERR_CSUM : `ERR_EMPTY;
                  end
               end
               default: r_st_q <= R_HUNT;
            endcase
         end
      end
   end
   byte_skid u_skid (
      .clk       (clk),
      .rst       (rst),
      .in_data   (b_in),
      .in_valid  (b_in_v),
      .in_ready  (b_in_rdy),
      .out_data  (b_out),
      .out_valid (b_out_v),
      .out_ready (rx_ready & ~rx_valid)
   );
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_data  <= 8'h00;
         rx_valid <= 1'b0;
         rx_last  <= 1'b0;
      end else if (rx_valid) begin
         if (rx_ready)
            rx_valid <= 1'b0;
      end else if (b_out_v & rx_ready) begin
         rx_data  <= b_out[7:0];
         rx_last  <= b_out[8];
         rx_valid <= 1'b1;
      end
   end
endmodule // api_frame_codec
`default_nettype wire

// ==== bench/api_device_model.sv ====
// device-side peer of the serial api codec
// assumes tb drives its line bytes through task put
`timescale 1ns/1ns
`default_nettype none
module api_device_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] api_mode_select,
   input  wire logic [7:0] ser_tx_data,
   input  wire logic       ser_tx_valid,
   output logic            ser_tx_ready,
   output logic [7:0]      ser_rx_data,
   output logic            ser_rx_valid,
   input  wire logic       slow
);
   logic [7:0] raw[$];
   logic [7:0] sum, b;
   logic       sync, esc, tgl;
   logic [15:0] len;
   int         n, bad;
   // slow far side accepts every other cycle
   assign ser_tx_ready = slow ? tgl : 1'b1;
   initial begin
      ser_rx_data = 8'h00;
      ser_rx_valid = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   // one byte per call; released line shows inverse of last
   task put(input logic [7:0] d, input logic v);
      @(posedge clk);
      ser_rx_data <= v ? d : ~ser_rx_data;
      ser_rx_valid <= v;
   endtask
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tgl <= 1'b0;
         sync = 1'b0;
         bad = 0;
      end else begin
         tgl <= ~tgl;
         if (ser_tx_valid && ser_tx_ready) begin
            raw.push_back(ser_tx_data);
            if (ser_tx_data == 8'h7E) begin
               sync = 1'b1;
               esc = 1'b0;
               n = 0;
               sum = 8'h00;
            end
            else if (sync) begin
               if (api_mode_select == 2'h2 && ser_tx_data == 8'h7D) esc = 1'b1;
               else begin
                  b = esc ? ser_tx_data ^ 8'h20 : ser_tx_data;
                  esc = 1'b0;
                  if (n == 0) len[15:8] = b;
                  if (n == 1) len[7:0] = b;
                  if (n >= 2) sum = sum + b;
                  // bad frame owed a status reply
                  if (n >= 2 && n == len + 2 && sum != 8'hFF) bad = bad + 1;
                  n = n + 1;
               end
            end
         end
      end
   end
endmodule // api_device_model
`default_nettype wire

// ==== bench/api_frame_codec_assertions.sv ====
// port-level checker for the api frame codec
// assumes bind onto the codec top module
`timescale 1ns/1ns
`default_nettype none
module api_frame_codec_checker (
   input wire       clk,
   input wire       rst,
   input wire [1:0] api_mode_select,
   input wire       tx_valid,
   input wire       tx_last,
   input wire       tx_ready,
   input wire [7:0] ser_tx_data,
   input wire       ser_tx_valid,
   input wire       ser_tx_ready,
   input wire [7:0] rx_data,
   input wire       rx_valid,
   input wire       rx_last,
   input wire       rx_ready,
   input wire       rx_frame_ok,
   input wire       rx_frame_err,
   input wire [1:0] rx_err_code
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire ta = tx_valid && tx_ready && tx_last && api_mode_select != 2'h0;
   wire sa = ser_tx_valid && ser_tx_ready;
   sequence s_esc;
      sa && api_mode_select == 2'h2 && ser_tx_data == 8'h7D;
   endsequence
   sequence s_xored;
      ser_tx_valid && ser_tx_data inside {8'h5E, 8'h5D, 8'h31, 8'h33};
   endsequence
   a_esc_follows: assert property (s_esc |=> s_xored)
      else $error("escape byte not followed by xored value");
   a_ctl_hidden: assert property (ser_tx_valid && api_mode_select == 2'h2 |->
      !(ser_tx_data inside {8'h11, 8'h13})) else $error("flow control byte sent raw");
   a_start_first: assert property (ta |=> ##1 ser_tx_valid && ser_tx_data == 8'h7E)
      else $error("frame did not open with start byte");
   a_busy_frame: assert property (ta |=> !tx_ready [*4])
      else $error("data taken while frame serialises");
   a_ser_holds: assert property (ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data))
      else $error("line byte changed before accepted");
   a_rx_holds: assert property (rx_valid && !rx_ready |=> rx_valid && $stable({rx_data, rx_last}))
      else $error("received byte changed while stalled");
   a_ok_pulse: assert property (rx_frame_ok |=> !rx_frame_ok)
      else $error("frame good flag longer than a cycle");
   a_ok_err_excl: assert property (!(rx_frame_ok && rx_frame_err))
      else $error("good and bad frame flagged together");
   a_err_coded: assert property (rx_frame_err |-> ##[0:1] rx_err_code != 2'h0)
      else $error("frame error without a code");
endmodule // api_frame_codec_checker
bind api_frame_codec api_frame_codec_checker api_frame_codec_checker_inst (.*);
`default_nettype wire

// ==== bench/tb_api_frame_codec.sv ====
// self-checking bench for the api frame codec
// assumes device model and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_api_frame_codec;
   logic       clk, rst, tx_valid, tx_last, rx_ready, slow;
   logic [1:0] api_mode_select;
   logic [7:0] tx_data;
   wire        tx_ready, ser_tx_valid, ser_tx_ready, ser_rx_valid;
   wire        rx_valid, rx_last, rx_frame_ok, rx_frame_err, rx_overflow;
   wire  [7:0] ser_tx_data, ser_rx_data, rx_data;
   wire  [1:0] rx_err_code;
   int         failures, total_checks, n_ok, n_err, n_ovf, i;
   logic [8:0] got[$];
   logic [7:0] fd[$], ex[$];
   api_frame_codec api_frame_codec_inst (.clk, .rst, .api_mode_select, .tx_data, .tx_valid, .tx_last,
      .tx_ready, .ser_tx_data, .ser_tx_valid, .ser_tx_ready, .ser_rx_data, .ser_rx_valid, .rx_data,
      .rx_valid, .rx_last, .rx_frame_ok, .rx_frame_err, .rx_err_code, .rx_ready, .rx_overflow);
   api_device_model api_device_model_inst (.clk, .rst, .api_mode_select, .ser_tx_data,
      .ser_tx_valid, .ser_tx_ready, .ser_rx_data, .ser_rx_valid, .slow);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back({rx_last, rx_data});
      if (rx_frame_ok === 1'b1) n_ok++;
      if (rx_frame_err === 1'b1) n_err++;
      if (rx_overflow === 1'b1) n_ovf++;
   end
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wrap_up;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // expected wire form of one byte
   function automatic void wput(input logic [7:0] b, input logic e);
      if (e && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13)) begin
         ex.push_back(8'h7D);
         ex.push_back(b ^ 8'h20);
      end else ex.push_back(b);
   endfunction
   task tx_frame(input logic [1:0] m);
      logic [7:0] s;
      s = 8'h00;
      ex = {8'h7E};
      api_device_model_inst.raw.delete();
      api_mode_select <= m;
      @(posedge clk);
      foreach (fd[k]) s = s + fd[k];
      wput(8'(fd.size() >> 8), m == 2'h2);
      wput(8'(fd.size()), m == 2'h2);
      foreach (fd[k]) wput(fd[k], m == 2'h2);
      wput(8'hFF - s, m == 2'h2);
      foreach (fd[k]) begin
         tx_data <= fd[k];
         tx_valid <= 1'b1;
         tx_last <= (k == fd.size() - 1);
         @(negedge clk);
         while (tx_ready !== 1'b1) @(negedge clk);
         @(posedge clk);
      end
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      for (i = 0; i < 300 && api_device_model_inst.raw.size() < ex.size(); i++) @(posedge clk);
      check("wire count", api_device_model_inst.raw.size(), ex.size());
      foreach (ex[k]) check("wire byte", api_device_model_inst.raw[k], ex[k]);
      check("device sum", api_device_model_inst.sum, 8'hFF);
      check("owed status", api_device_model_inst.bad, 0);
   endtask
   task rx_send(input logic [1:0] m);
      @(posedge clk);
      api_mode_select <= m;
      foreach (fd[k]) api_device_model_inst.put(fd[k], 1'b1);
      api_device_model_inst.put(8'h00, 1'b0);
      repeat (12) @(posedge clk);
   endtask
   task clr;
      @(negedge clk);
      got.delete();
      n_ok = 0;
      n_err = 0;
      n_ovf = 0;
   endtask
   ////////////////////////////////////////////////////////////
   task t_tx;
      slow <= 1'b0;
      fd = {8'h08};
      tx_frame(2'h1);
      fd = {8'h17, 8'h7D, 8'h11, 8'h13};
      tx_frame(2'h1);
      slow <= 1'b1;
      fd = {8'h17, 8'h7E, 8'h7D, 8'h11, 8'h13, 8'h4B};
      tx_frame(2'h2);
      fd.delete();
      for (i = 0; i < 17; i++) fd.push_back(8'(i));
      tx_frame(2'h2);
      slow <= 1'b0;
   endtask
   task t_rx_good;
      clr;
      fd = {8'h55, 8'h13, 8'h7E, 8'h00, 8'h02, 8'h08, 8'h52, 8'hA5};
      rx_send(2'h1);
      check("ok pulses", n_ok, 1);
      check("rx count", got.size(), 2);
      check("rx first", got[0], 9'h008);
      check("rx last", got[1], 9'h152);
   endtask
   task t_rx_bad;
      clr;
      fd = {8'h7E, 8'h00, 8'h02, 8'h08, 8'h52, 8'h00};
      rx_send(2'h1);
      check("err pulses", n_err, 1);
      check("ok pulses", n_ok, 0);
      check("rx count", got.size(), 1);
      check("err code", rx_err_code, 2'h1);
      clr;
      fd = {8'h7E, 8'h00, 8'h00, 8'hFF};
      rx_send(2'h1);
      check("empty errs", n_err, 1);
      check("empty code", rx_err_code, 2'h3);
   endtask
   task t_rx_esc;
      clr;
      fd = {8'h7E, 8'h00, 8'h03, 8'h08, 8'h7E, 8'h00, 8'h02, 8'h08, 8'h7D, 8'h31, 8'hE6};
      rx_send(2'h2);
      check("abort errs", n_err, 1);
      check("ok pulses", n_ok, 1);
      check("rx last", got[got.size() - 1], 9'h111);
   endtask
   task t_overflow;
      clr;
      @(posedge clk);
      rx_ready <= 1'b0;
      fd = {8'h7E, 8'h00, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04, 8'hF5};
      rx_send(2'h1);
      check("overflow", n_ovf, 2);
      rx_ready <= 1'b1;
      repeat (10) @(posedge clk);
      @(negedge clk);
      check("kept first", got[0], 9'h001);
      check("kept count", got.size(), 2);
      check("drained", rx_valid, 1'b0);
   endtask
   task t_transp;
      clr;
      api_device_model_inst.raw.delete();
      api_mode_select <= 2'h0;
      @(posedge clk);
      tx_data <= 8'h7E;
      tx_valid <= 1'b1;
      @(posedge clk);
      tx_valid <= 1'b0;
      api_device_model_inst.put(8'h7D, 1'b1);
      api_device_model_inst.put(8'h00, 1'b0);
      repeat (8) @(posedge clk);
      check("raw count", api_device_model_inst.raw.size(), 1);
      check("raw tx", api_device_model_inst.raw[0], 8'h7E);
      check("raw rx", got[0], 9'h07D);
   endtask
   initial begin
      rst = 1'b1;
      tx_valid = 1'b0;
      tx_last = 1'b0;
      tx_data = 8'h00;
      rx_ready = 1'b1;
      slow = 1'b0;
      api_mode_select = 2'h1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_tx;
      t_rx_good;
      t_rx_bad;
      t_rx_esc;
      t_overflow;
      t_transp;
      wrap_up;
   end
   initial begin
      #200000;
      failures++;
      wrap_up;
   end
endmodule // tb_api_frame_codec
`default_nettype wire
